// ===== hw/smc_params.svh
// Register map, field positions, reset values and counts for the shared
// I2C mode configuration block. Included by the package and all modules except the bus model.
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

`define SMC_ADR_W 8
`define SMC_CFG_OFS 8'h00
`define SMC_ISTAT_OFS 8'hF0
`define SMC_IMASK_OFS 8'hF4
`define SMC_TOVAL_OFS 8'hF8
`define SMC_MONDAT_OFS 8'hFC

`define SMC_CFG_W 5
`define SMC_CFG_CTL 0
`define SMC_CFG_TGT 1
`define SMC_CFG_MON 2
`define SMC_CFG_TO 3
`define SMC_CFG_STR 4
`define SMC_CFG_RST 5'h00

`define SMC_EV_W 4
`define SMC_EV_MDATA 0
`define SMC_EV_MOVR 1
`define SMC_EV_EVTO 2
`define SMC_EV_SCLTO 3
`define SMC_EV_RST 4'h0

`define SMC_TOVAL_W 16
`define SMC_TOVAL_RST 16'hFFFF
`define SMC_TO_DIV 4'hF
`define SMC_MON_BITS 4'h8

`endif

// ===== hw/smc_pkg.sv
// Types for the shared I2C mode configuration block.
// Assumes smc_params.svh is on the include path.
`include "smc_params.svh"

package smc_pkg;

  typedef enum logic [1:0] {
    SMC_MON_IDLE = 2'b01,
    SMC_MON_RECV = 2'b10
  } smc_mon_state_e;

  typedef struct packed {
    smc_mon_state_e st;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic [8:0] sh;
    logic [8:0] data;
    logic valid;
    logic ovr;
    logic str;
  } smc_mon_s;

  typedef struct packed {
    logic [3:0] div;
    logic scl_p;
    logic sda_p;
    logic busy;
    logic [`SMC_TOVAL_W-1:0] ecnt;
    logic [`SMC_TOVAL_W-1:0] scnt;
    logic eto;
    logic sto;
  } smc_to_s;

  typedef struct packed {
    logic [`SMC_CFG_W-1:0] cfg;
    logic [`SMC_EV_W-1:0] mask;
    logic [`SMC_EV_W-1:0] stat;
    logic [`SMC_TOVAL_W-1:0] toval;
    logic ack;
    logic [31:0] rdat;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
  } smc_top_s;

endpackage

// ===== hw/smc_monitor.sv
// Bus monitor: captures each byte plus its acknowledge bit from SCL/SDA.
// Assumes synchronised SCL/SDA and a reset that also covers disable.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_monitor
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic stretch_en_i,
  input wire logic rd_i,
  output logic valid_o,
  output logic [8:0] data_o,
  output logic ovr_o,
  output logic stretch_o
);

  smc_mon_s q, d;
  logic start_w, stop_w, rise_w;

  assign start_w = scl_i & q.scl_p & q.sda_p & ~sda_i;
  assign stop_w = scl_i & q.scl_p & ~q.sda_p & sda_i;
  assign rise_w = scl_i & ~q.scl_p;

  always_comb begin
    d = q;
    d.ovr = 1'b0;
    d.scl_p = scl_i;
    d.sda_p = sda_i;
    if (rd_i) begin
      d.valid = 1'b0;
    end
    case (q.st)
      SMC_MON_IDLE: begin
        if (start_w) begin
          d.st = SMC_MON_RECV;
          d.cnt = 4'h0;
        end
      end
      SMC_MON_RECV: begin
        if (stop_w) begin
          d.st = SMC_MON_IDLE;
        end else if (start_w) begin
          d.cnt = 4'h0;
        end else if (rise_w) begin
          d.sh = {q.sh[7:0], sda_i};
          if (q.cnt == `SMC_MON_BITS) begin
            d.cnt = 4'h0;
            // Without stretching an unread byte is simply overwritten
            d.ovr = q.valid & ~rd_i;
            d.data = {q.sh[7:0], sda_i};
            d.valid = 1'b1;
          end else begin
            d.cnt = q.cnt + 4'h1;
          end
        end
      end
      default: d.st = SMC_MON_IDLE;
    endcase
    // Hold SCL low once it is low and a byte waits to be read
    d.str = stretch_en_i & d.valid & ~scl_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: SMC_MON_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign valid_o = q.valid;
  assign data_o = q.data;
  assign ovr_o = q.ovr;
  assign stretch_o = q.str;

endmodule // smc_monitor
`default_nettype wire

// ===== hw/smc_timeout.sv
// Bus time-out detection: event time-out and SCL-low time-out.
// Assumes synchronised SCL/SDA; reset is held while time-out is disabled.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_timeout
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [`SMC_TOVAL_W-1:0] limit_i,
  output logic evt_to_o,
  output logic scl_to_o
);

  smc_to_s q, d;
  logic tick_w, edge_w;

  assign tick_w = (q.div == `SMC_TO_DIV);
  assign edge_w = (scl_i ^ q.scl_p) | (sda_i ^ q.sda_p);

  always_comb begin
    d = q;
    d.eto = 1'b0;
    d.sto = 1'b0;
    d.scl_p = scl_i;
    d.sda_p = sda_i;
    d.div = tick_w ? 4'h0 : q.div + 4'h1;
    if (q.scl_p & scl_i & (sda_i ^ q.sda_p)) begin
      d.busy = ~sda_i;
    end
    // No bus activity for too long while a transfer is open
    if (~q.busy | edge_w) begin
      d.ecnt = '0;
    end else if (tick_w) begin
      if (q.ecnt == limit_i) begin
        d.eto = 1'b1;
        d.ecnt = '0;
      end else begin
        d.ecnt = q.ecnt + 16'h0001;
      end
    end
    // SCL held low for too long
    if (scl_i) begin
      d.scnt = '0;
    end else if (tick_w) begin
      if (q.scnt == limit_i) begin
        d.sto = 1'b1;
        d.scnt = '0;
      end else begin
        d.scnt = q.scnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{scl_p: 1'b1, sda_p: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign evt_to_o = q.eto;
  assign scl_to_o = q.sto;

endmodule // smc_timeout
`default_nettype wire

// ===== hw/smc_shared_cfg.sv
// Shared mode configuration of an I2C interface: Wishbone registers,
// per-function internal resets, monitor, time-out and interrupt.
// Assumes classic Wishbone on clk_i and an open-drain SCL/SDA outside.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_shared_cfg
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SMC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic ctl_func_rst_o,
  output logic tgt_func_rst_o,
  output logic irq_o
);

  smc_top_s q, d;

  logic req_w, wr_w, rd_w;
  logic mon_rst_w, to_rst_w;
  logic mon_valid_w, mon_ovr_w, mon_str_w, mon_rd_w;
  logic [8:0] mon_data_w;
  logic evt_to_w, scl_to_w;
  logic [`SMC_EV_W-1:0] ev_w;

  assign req_w = wb_cyc_i & wb_stb_i;
  // Writes and read side effects happen on the edge that carries ack
  assign wr_w = req_w & wb_we_i & q.ack;
  assign rd_w = req_w & ~wb_we_i & q.ack;

  // Function resets follow the stored enables directly
  assign ctl_func_rst_o = rst_i | ~q.cfg[`SMC_CFG_CTL];
  assign tgt_func_rst_o = rst_i | ~q.cfg[`SMC_CFG_TGT];
  assign mon_rst_w = rst_i | ~q.cfg[`SMC_CFG_MON];
  assign to_rst_w = rst_i | ~q.cfg[`SMC_CFG_TO];

  assign mon_rd_w = rd_w & (wb_adr_i == `SMC_MONDAT_OFS);

  smc_monitor u_monitor (
    .clk_i(clk_i),
    .rst_i(mon_rst_w),
    .scl_i(q.scl_s2),
    .sda_i(q.sda_s2),
    .stretch_en_i(q.cfg[`SMC_CFG_STR]),
    .rd_i(mon_rd_w),
    .valid_o(mon_valid_w),
    .data_o(mon_data_w),
    .ovr_o(mon_ovr_w),
    .stretch_o(mon_str_w)
  );

  smc_timeout u_timeout (
    .clk_i(clk_i),
    .rst_i(to_rst_w),
    .scl_i(q.scl_s2),
    .sda_i(q.sda_s2),
    .limit_i(q.toval),
    .evt_to_o(evt_to_w),
    .scl_to_o(scl_to_w)
  );

  always_comb begin
    ev_w = '0;
    ev_w[`SMC_EV_MDATA] = mon_valid_w;
    ev_w[`SMC_EV_MOVR] = mon_ovr_w;
    ev_w[`SMC_EV_EVTO] = evt_to_w;
    ev_w[`SMC_EV_SCLTO] = scl_to_w;
  end

  always_comb begin
    d = q;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.ack = req_w & ~q.ack;
    if (wr_w) begin
      case (wb_adr_i)
        `SMC_CFG_OFS: begin
          if (wb_sel_i[0]) begin
            d.cfg = wb_dat_i[`SMC_CFG_W-1:0];
          end
        end
        `SMC_ISTAT_OFS: begin
          if (wb_sel_i[0]) begin
            d.stat = q.stat & ~wb_dat_i[`SMC_EV_W-1:0];
          end
        end
        `SMC_IMASK_OFS: begin
          if (wb_sel_i[0]) begin
            d.mask = wb_dat_i[`SMC_EV_W-1:0];
          end
        end
        `SMC_TOVAL_OFS: begin
          if (wb_sel_i[0]) begin
            d.toval[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            d.toval[15:8] = wb_dat_i[15:8];
          end
        end
        default: d.cfg = q.cfg;
      endcase
    end
    // Hardware set wins over a write-one clear in the same cycle
    d.stat = d.stat | ev_w;
    d.rdat = 32'h0000_0000;
    if (req_w & ~q.ack & ~wb_we_i) begin
      case (wb_adr_i)
        `SMC_CFG_OFS: d.rdat[`SMC_CFG_W-1:0] = q.cfg;
        `SMC_ISTAT_OFS: d.rdat[`SMC_EV_W-1:0] = q.stat;
        `SMC_IMASK_OFS: d.rdat[`SMC_EV_W-1:0] = q.mask;
        `SMC_TOVAL_OFS: d.rdat[`SMC_TOVAL_W-1:0] = q.toval;
        `SMC_MONDAT_OFS: d.rdat[8:0] = mon_data_w;
        default: d.rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{cfg: `SMC_CFG_RST, mask: `SMC_EV_RST, stat: `SMC_EV_RST,
             toval: `SMC_TOVAL_RST, scl_s1: 1'b1, scl_s2: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign irq_o = |(q.stat & q.mask);
  // Open drain: SCL is only ever pulled low by the monitor stretch
  assign scl_o = 1'b0;
  assign scl_oe_o = mon_str_w;
  assign sda_o = 1'b0;
  assign sda_oe_o = 1'b0;

  // Checks
  sequence s_cfg_write(int bitpos, bit val);
    wr_w && wb_adr_i == `SMC_CFG_OFS && wb_sel_i[0] && wb_dat_i[bitpos] == val;
  endsequence

  sequence s_evt_seen;
    evt_to_w && !to_rst_w;
  endsequence

  a_ctl_rst_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cfg_write(`SMC_CFG_CTL, 1'b0) |=> ctl_func_rst_o)
    else $error("controller not reset after enable cleared");

  a_tgt_rst_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cfg_write(`SMC_CFG_TGT, 1'b1) |=> !tgt_func_rst_o ##1 !tgt_func_rst_o)
    else $error("target enable not taking effect on next edge");

  a_mon_held_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cfg_write(`SMC_CFG_MON, 1'b0) |=> mon_rst_w ##1 !mon_valid_w)
    else $error("monitor not held in reset when disabled");

  a_timeout_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (to_rst_w && $past(to_rst_w)) |-> !evt_to_w && !scl_to_w)
    else $error("time-out flag while time-out disabled");

  a_timeout_flagged: assert property (@(posedge clk_i) disable iff (rst_i)
    s_evt_seen ##1 q.mask[`SMC_EV_EVTO] |-> q.stat[`SMC_EV_EVTO] && irq_o)
    else $error("event time-out not flagged or not interrupting");

  a_no_stretch_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!q.cfg[`SMC_CFG_STR] && !$past(q.cfg[`SMC_CFG_STR])) |-> !scl_oe_o)
    else $error("monitor stretched SCL with stretching off");

  a_no_overrun_str: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.cfg[`SMC_CFG_STR] && $past(q.cfg[`SMC_CFG_STR], 2)) |-> !mon_ovr_w)
    else $error("monitor data overwritten while stretching");

  a_stretch_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    (scl_oe_o && !mon_rd_w && !mon_rst_w && q.cfg[`SMC_CFG_STR] && !scl_i)
      |=> scl_oe_o || !q.cfg[`SMC_CFG_STR] || mon_rst_w)
    else $error("stretch released before data read");

  a_wb_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  a_cfg_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_w && wb_adr_i == `SMC_CFG_OFS && wb_sel_i[0])
      |=> q.cfg == $past(wb_dat_i[`SMC_CFG_W-1:0]))
    else $error("config write not stored on ack edge");

endmodule // smc_shared_cfg
`default_nettype wire

// ===== tb/smc_bus_model.sv
// Model of an I2C controller driving SCL/SDA through open-drain pulls.
// Assumes pull-ups on both lines and the wired SCL level fed back.
`timescale 1ns/1ps
`default_nettype none

module smc_bus_model (
  input wire logic scl_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic start_cond();
    sda_low_o = 1'b1;
    #80;
  endtask

  // One bit per 160 ns period; waits while another party stretches SCL
  task automatic bit_out(input logic b);
    int n;
    scl_low_o = 1'b1;
    #20;
    sda_low_o = ~b;
    #60;
    scl_low_o = 1'b0;
    for (n = 0; n < 5000 && scl_i !== 1'b1; n++) #8;
    #80;
  endtask

  task automatic send_item(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) bit_out(v[i]);
    scl_low_o = 1'b1;
    #80;
  endtask

  task automatic stop_cond();
    int n;
    sda_low_o = 1'b1;
    #40;
    scl_low_o = 1'b0;
    // A stretched SCL must be seen high before SDA may rise
    for (n = 0; n < 5000 && scl_i !== 1'b1; n++) #8;
    #80;
    sda_low_o = 1'b0;
    #80;
  endtask

  task automatic hold_scl_low(input int ns);
    scl_low_o = 1'b1;
    #(ns);
    scl_low_o = 1'b0;
  endtask
endmodule // smc_bus_model

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the shared I2C mode configuration block.
// Assumes smc_pkg, smc_params.svh and the bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module tb_top;
  import smc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, str_seen;
  logic scl_o, scl_oe, sda_o, sda_oe, ctl_rst, tgt_rst, scl_low, sda_low;
  logic [7:0] adr;
  logic [3:0] sel, wsel;
  logic [31:0] wdat, rdat, q;
  int failures = 0;
  int n_checks = 0;
  wire scl_w = ~(scl_low | (scl_oe & ~scl_o));
  wire sda_w = ~(sda_low | (sda_oe & ~sda_o));

  smc_shared_cfg u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .ctl_func_rst_o(ctl_rst), .tgt_func_rst_o(tgt_rst),
    .irq_o(irq));
  smc_bus_model u_bus (.scl_i(scl_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (scl_oe === 1'b1) str_seen <= 1'b1;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic single cycle; ack and read data are taken at one rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) begin
      failures++;
      stop_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask

  task automatic pin(input string nm, input logic s, e);
    chk(nm, {31'h0, s}, {31'h0, e});
  endtask

  task automatic wait_str();
    int n;
    for (n = 0; n < 3000 && scl_oe !== 1'b1; n++) @(posedge clk_i);
    if (scl_oe !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic t_reset();
    pin("ctl_rst", ctl_rst, 1'b1);
    pin("tgt_rst", tgt_rst, 1'b1);
    pin("sda_oe", sda_oe, 1'b0);
    pin("sda_o", sda_o, 1'b0);
    rd("cfg", 8'h00, 32'h0000_0000);
    rd("toval", 8'hF8, 32'h0000_FFFF);
    rd("unmapped", 8'h40, 32'h0000_0000);
  endtask

  task automatic t_enables();
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, 32'h1 << i);
      rd("cfg bit", 8'h00, 32'h1 << i);
      pin("ctl_rst", ctl_rst, i != 0);
      pin("tgt_rst", tgt_rst, i != 1);
    end
    wb(1'b1, 8'hF8, 32'h0000_0004);
    // Only lane 1 enabled: high limit byte lands, config write is ignored
    wsel = 4'h2;
    wb(1'b1, 8'hF8, 32'h0000_0305);
    rd("toval lane1", 8'hF8, 32'h0000_0304);
    wb(1'b1, 8'h00, 32'h0000_001F);
    rd("cfg lane1", 8'h00, 32'h0000_0010);
    wb(1'b1, 8'hF8, 32'h0000_0000);
    wsel = 4'hF;
    wb(1'b1, 8'h00, 32'h0000_001F);
    wb(1'b1, 8'h00, 32'h0000_0000);
    pin("ctl_rst off", ctl_rst, 1'b1);
    rd("toval kept", 8'hF8, 32'h0000_0004);
  endtask

  task automatic t_monitor();
    wb(1'b1, 8'h00, 32'h0000_0004);
    wb(1'b1, 8'hF4, 32'h0000_0003);
    str_seen <= 1'b0;
    u_bus.start_cond();
    u_bus.send_item(9'h14A);
    u_bus.send_item(9'h079);
    u_bus.stop_cond();
    pin("no stretch", str_seen, 1'b0);
    rd("stat", 8'hF0, 32'h0000_0003);
    pin("irq", irq, 1'b1);
    wb(1'b1, 8'hF4, 32'h0000_0000);
    pin("irq masked", irq, 1'b0);
    rd("last item", 8'hFC, 32'h0000_0079);
    wb(1'b1, 8'hF0, 32'h0000_000F);
    rd("stat clr", 8'hF0, 32'h0000_0000);
  endtask

  task automatic t_stretch();
    wb(1'b1, 8'h00, 32'h0000_0014);
    fork
      begin
        u_bus.start_cond();
        u_bus.send_item(9'h14A);
        u_bus.send_item(9'h079);
        u_bus.stop_cond();
      end
      begin
        wait_str();
        pin("scl_o", scl_o, 1'b0);
        rd("item 1", 8'hFC, 32'h0000_014A);
        pin("released", scl_oe, 1'b0);
        wait_str();
        rd("item 2", 8'hFC, 32'h0000_0079);
      end
    join
    // Data-ready stays sticky; the overrun bit must stay clear
    rd("no ovr", 8'hF0, 32'h0000_0001);
  endtask

  task automatic t_timeout();
    wb(1'b1, 8'h00, 32'h0000_0000);
    wb(1'b1, 8'hF0, 32'h0000_000F);
    wb(1'b1, 8'hF4, 32'h0000_000C);
    u_bus.hold_scl_low(2000);
    rd("to off", 8'hF0, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0008);
    u_bus.start_cond();
    #2000;
    u_bus.hold_scl_low(2000);
    u_bus.stop_cond();
    rd("both flags", 8'hF0, 32'h0000_000C);
    pin("to irq", irq, 1'b1);
    wb(1'b1, 8'hF0, 32'h0000_000C);
    pin("irq clr", irq, 1'b0);
  endtask

  task automatic t_rerun();
    wb(1'b1, 8'h00, 32'h0000_0003);
    pin("ctl_rst on", ctl_rst, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pin("ctl_rst rst", ctl_rst, 1'b1);
    pin("tgt_rst rst", tgt_rst, 1'b1);
    rd("cfg rst", 8'h00, 32'h0000_0000);
    rd("toval rst", 8'hF8, 32'h0000_FFFF);
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    str_seen = 1'b0;
    wsel = 4'hF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_enables();
    t_monitor();
    t_stretch();
    t_timeout();
    t_rerun();
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
